// >>> src/global_ctrl_map.vh
// Register map, field positions, reset values and timing constants
// for the global control bank of the switch.
// Assumes it is included by bare name from files under src/.
`ifndef GLOBAL_CTRL_MAP_VH
`define GLOBAL_CTRL_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_VID_STORM_HIGH 8'h06
`define ADDR_STORM_LOW 8'h07
`define ADDR_FACTORY_A 8'h08
`define ADDR_FACTORY_B 8'h09
`define ADDR_FACTORY_C 8'h0a
`define ADDR_CLK_LED_PWR 8'h0b

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_STORM_HIGH 3'h0
`define RST_STORM_LOW 8'h4a
`define RST_FACTORY_A 8'h00
`define RST_FACTORY_B 8'h4c
`define RST_FACTORY_C 8'h00
`define RDATA_ZERO 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_NULL_VID_REPL 3
`define FLD_STORM_HIGH_MSB 2
`define FLD_STORM_HIGH_LSB 0
`define BIT_THIRD_EDGE 7
`define BIT_FOURTH_EDGE 6
`define BIT_POWER_SAVE 3
`define BIT_LED_MODE 1
`define BIT_READ_EDGE 0

// ----------------------------------------------------------------------
// Identifier and timing constants
// ----------------------------------------------------------------------
`define VID_NULL 12'h000
`define CLK_KHZ 25000
`define WINDOW_FAST_MS 50
`define WINDOW_SLOW_MS 500
`define STRAP_SETTLE 2'h3

`endif

// >>> src/sync_2ff.v
// Two flip-flop synchroniser for levels arriving from pins.
// Assumes the input is a slow level such as a strap.
module sync_2ff #(
    parameter WIDTH = 1
) (
    // Clock and control
    input wire clk_i,
    input wire ce_i,
    // Asynchronous level in, synchronised level out
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_i) begin
        if (ce_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // sync_2ff

// >>> src/storm_port_meter.v
// Broadcast storm meter for one input port: counts 64-byte blocks in a
// timed window and drops blocks beyond the threshold.
// Assumes speed and block strobes come from logic on the same clock.
`include "global_ctrl_map.vh"

module storm_port_meter #(
    parameter WIN_W = 24,
    parameter [WIN_W-1:0] FAST_CYCLES = 24'h13_12d0,
    parameter [WIN_W-1:0] SLOW_CYCLES = 24'hbe_bc20
) (
    // Clock, reset and enable
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    // Port state and threshold
    input wire fast_speed_i,
    input wire [10:0] threshold_i,
    input wire block_seen_i,
    // Results
    output reg block_drop_o,
    output reg limited_o
);

    localparam [WIN_W-1:0] ONE = 1;
    localparam [WIN_W-1:0] TIMER_ZERO = 0;

    reg [WIN_W-1:0] timer_q;
    reg [10:0] count_q;
    wire window_end;
    wire [10:0] count_base;
    wire accept;

    assign window_end = (timer_q == TIMER_ZERO);
    // A new window starts from zero blocks.
    assign count_base = window_end ? 11'h000 : count_q;
    assign accept = (count_base < threshold_i);

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_q <= TIMER_ZERO;
            count_q <= 11'h000;
            block_drop_o <= 1'b0;
            limited_o <= 1'b0;
        end else if (ce_i) begin
            if (window_end) begin
                // Window length follows the port's present speed.
                timer_q <= fast_speed_i ? FAST_CYCLES - ONE
                                        : SLOW_CYCLES - ONE;
            end else begin
                timer_q <= timer_q - ONE;
            end
            if (block_seen_i && accept) begin
                count_q <= count_base + 11'h001;
            end else begin
                count_q <= count_base;
            end
            block_drop_o <= block_seen_i && !accept;
            limited_o <= !accept;
        end
    end

endmodule // storm_port_meter

// >>> src/switch_global_control_bank.v
// Global control registers 0x06 to 0x0b of the switch and the logic
// they steer: null VLAN-ID replacement, broadcast storm limiting,
// reduced MII sampling edges, PHY power save, LED mode, read edge.
// Assumes the serial management port drives the register strobes on
// clk_i and that the LED mode strap pin is asynchronous.
`include "global_ctrl_map.vh"

// Summary of operation
// - Bit 3 set replaces null VLAN ID with port default VID.
// - Storm threshold is 11 bits: high three from 0x06, low byte 0x07.
// - Window lasts 50 ms at 100 Mbit, 500 ms at 10 Mbit; restarts.
// - Threshold resets to 000 high bits and 0x4A low byte.
// - Factory test registers read 0x00, 0x4C, 0x00 and ignore writes.
// - Clocking bit 6 set samples fourth port reduced MII on falling edge.
// - Bit 1 picks LED mode; reset value taken from strap pin.
// - Bit 0 set launches management read data on rising edge.
module switch_global_control_bank #(
    parameter NUM_PORTS = 4,
    parameter NUM_PHYS = 2,
    parameter [23:0] FAST_WINDOW_CYCLES =
        `WINDOW_FAST_MS * `CLK_KHZ,
    parameter [23:0] SLOW_WINDOW_CYCLES =
        `WINDOW_SLOW_MS * `CLK_KHZ
) (
    // Clock, reset and enable
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    // Register access from the serial management port
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // VLAN identifier path
    input wire vid_valid_i,
    input wire [11:0] vid_in_i,
    input wire [11:0] port_default_vid_i,
    output reg vid_valid_o,
    output reg [11:0] vid_out_o,
    // Broadcast storm metering per input port
    input wire [NUM_PORTS-1:0] fast_port_speed_i,
    input wire [NUM_PORTS-1:0] block_seen_i,
    output wire [NUM_PORTS-1:0] block_drop_o,
    output wire [NUM_PORTS-1:0] storm_limited_o,
    // PHY status for the port LEDs
    input wire [NUM_PHYS-1:0] phy_link_i,
    input wire [NUM_PHYS-1:0] phy_act_i,
    input wire [NUM_PHYS-1:0] phy_fast_i,
    input wire [NUM_PHYS-1:0] phy_full_duplex_i,
    output reg [NUM_PHYS-1:0] port_led_first_o,
    output reg [NUM_PHYS-1:0] port_led_second_o,
    // Strap pin
    input wire led_mode_strap_pin_i,
    // Control levels to the rest of the switch
    output wire third_port_reduced_mii_neg_edge_o,
    output wire fourth_port_reduced_mii_neg_edge_o,
    output wire phy_power_save_o,
    output wire led_mode_o,
    output wire smi_read_rising_edge_o,
    output wire [10:0] storm_threshold_o
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg null_vid_repl_q;
    reg [2:0] storm_high_q;
    reg [7:0] storm_low_q;
    reg third_edge_q;
    reg fourth_edge_q;
    reg power_save_q;
    reg led_mode_q;
    reg read_edge_q;
    reg [1:0] strap_cnt_q;
    reg strap_done_q;
    reg [7:0] rdata_d;
    reg [11:0] vid_out_d;
    wire strap_sync;
    wire wr_vid;
    wire wr_low;
    wire wr_clk;
    wire [10:0] threshold;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    // The factory test offsets decode to no write enable at all, so
    // those registers keep their fixed values whatever software sends.
    assign wr_vid = reg_wr_i && (reg_addr_i == `ADDR_VID_STORM_HIGH);
    assign wr_low = reg_wr_i && (reg_addr_i == `ADDR_STORM_LOW);
    assign wr_clk = reg_wr_i && (reg_addr_i == `ADDR_CLK_LED_PWR);

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    sync_2ff #(
        .WIDTH(1)
    ) u_strap_sync (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .async_i(led_mode_strap_pin_i),
        .sync_o(strap_sync)
    );

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // The strap is loaded once the synchroniser has settled after
    // reset; a software write to 0x0b before that point wins and ends the wait.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            null_vid_repl_q <= 1'b0;
            storm_high_q <= `RST_STORM_HIGH;
            storm_low_q <= `RST_STORM_LOW;
            third_edge_q <= 1'b0;
            fourth_edge_q <= 1'b0;
            power_save_q <= 1'b0;
            led_mode_q <= 1'b0;
            read_edge_q <= 1'b0;
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
        end else if (ce_i) begin
            if (!strap_done_q) begin
                if (strap_cnt_q == `STRAP_SETTLE) begin
                    led_mode_q <= strap_sync;
                    strap_done_q <= 1'b1;
                end else begin
                    strap_cnt_q <= strap_cnt_q + 2'h1;
                end
            end
            if (wr_vid) begin
                null_vid_repl_q <= reg_wdata_i[`BIT_NULL_VID_REPL];
                storm_high_q <= reg_wdata_i[`FLD_STORM_HIGH_MSB:
                                            `FLD_STORM_HIGH_LSB];
            end
            if (wr_low) begin
                storm_low_q <= reg_wdata_i;
            end
            if (wr_clk) begin
                third_edge_q <= reg_wdata_i[`BIT_THIRD_EDGE];
                fourth_edge_q <= reg_wdata_i[`BIT_FOURTH_EDGE];
                power_save_q <= reg_wdata_i[`BIT_POWER_SAVE];
                led_mode_q <= reg_wdata_i[`BIT_LED_MODE];
                read_edge_q <= reg_wdata_i[`BIT_READ_EDGE];
                strap_done_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Reserved bits and unmapped offsets read as zero.
    always @* begin
        rdata_d = `RDATA_ZERO;
        case (reg_addr_i)
            `ADDR_VID_STORM_HIGH: begin
                rdata_d[`BIT_NULL_VID_REPL] = null_vid_repl_q;
                rdata_d[`FLD_STORM_HIGH_MSB:`FLD_STORM_HIGH_LSB] =
                    storm_high_q;
            end
            `ADDR_STORM_LOW: begin
                rdata_d = storm_low_q;
            end
            `ADDR_FACTORY_A: begin
                rdata_d = `RST_FACTORY_A;
            end
            `ADDR_FACTORY_B: begin
                rdata_d = `RST_FACTORY_B;
            end
            `ADDR_FACTORY_C: begin
                rdata_d = `RST_FACTORY_C;
            end
            `ADDR_CLK_LED_PWR: begin
                rdata_d[`BIT_THIRD_EDGE] = third_edge_q;
                rdata_d[`BIT_FOURTH_EDGE] = fourth_edge_q;
                rdata_d[`BIT_POWER_SAVE] = power_save_q;
                rdata_d[`BIT_LED_MODE] = led_mode_q;
                rdata_d[`BIT_READ_EDGE] = read_edge_q;
            end
            default: begin
                rdata_d = `RDATA_ZERO;
            end
        endcase
    end

    // Read data is captured only on a read strobe and then holds, so a
    // read and a write in one cycle return the old value.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= `RDATA_ZERO;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Null VLAN identifier replacement
    // ------------------------------------------------------------------
    // The outgoing identifier holds between valid pulses, so the frame
    // path may sample it late. Only an all-zero identifier is replaced;
    // any other value passes through untouched.
    always @* begin
        vid_out_d = vid_out_o;
        if (vid_valid_i) begin
            if (null_vid_repl_q && (vid_in_i == `VID_NULL)) begin
                vid_out_d = port_default_vid_i;
            end else begin
                vid_out_d = vid_in_i;
            end
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            vid_valid_o <= 1'b0;
            vid_out_o <= `VID_NULL;
        end else if (ce_i) begin
            vid_valid_o <= vid_valid_i;
            vid_out_o <= vid_out_d;
        end
    end

    // ------------------------------------------------------------------
    // Broadcast storm metering
    // ------------------------------------------------------------------
    // All ports share one threshold, but each meter keeps its own window
    // so ports running at different speeds are measured apart.
    assign threshold = {storm_high_q, storm_low_q};

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_storm
            storm_port_meter #(
                .WIN_W(24),
                .FAST_CYCLES(FAST_WINDOW_CYCLES),
                .SLOW_CYCLES(SLOW_WINDOW_CYCLES)
            ) u_meter (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .ce_i(ce_i),
                .fast_speed_i(fast_port_speed_i[p]),
                .threshold_i(threshold),
                .block_seen_i(block_seen_i[p]),
                .block_drop_o(block_drop_o[p]),
                .limited_o(storm_limited_o[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Port LEDs
    // ------------------------------------------------------------------
    // Activity blinks a lit link LED off.
    genvar l;
    generate
        for (l = 0; l < NUM_PHYS; l = l + 1) begin : g_led
            reg first_d;
            reg second_d;

            always @* begin
                if (led_mode_q) begin
                    first_d = phy_full_duplex_i[l];
                    second_d = phy_link_i[l] && phy_fast_i[l] &&
                        !phy_act_i[l];
                end else begin
                    first_d = phy_fast_i[l];
                    second_d = phy_link_i[l] && !phy_act_i[l];
                end
            end

            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    port_led_first_o[l] <= 1'b0;
                    port_led_second_o[l] <= 1'b0;
                end else if (ce_i) begin
                    port_led_first_o[l] <= first_d;
                    port_led_second_o[l] <= second_d;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Control levels
    // ------------------------------------------------------------------
    // The levels come straight from the register bits, so a write takes
    // effect on the same clock edge that takes it.
    assign third_port_reduced_mii_neg_edge_o = third_edge_q;
    assign fourth_port_reduced_mii_neg_edge_o = fourth_edge_q;
    assign phy_power_save_o = power_save_q;
    assign led_mode_o = led_mode_q;
    assign smi_read_rising_edge_o = read_edge_q;
    assign storm_threshold_o = threshold;

endmodule // switch_global_control_bank

// >>> testbench/gcb_checker.sv
// Concurrent checks on the ports of the global control bank.
// Assumes it is bound into the bank; one clock, sync active-low reset.
module gcb_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register access
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Identifier path
    input wire logic vid_valid_i,
    input wire logic [11:0] vid_in_i,
    input wire logic [11:0] port_default_vid_i,
    input wire logic vid_valid_o,
    input wire logic [11:0] vid_out_o,
    // Control levels
    input wire logic third_port_reduced_mii_neg_edge_o,
    input wire logic fourth_port_reduced_mii_neg_edge_o,
    input wire logic phy_power_save_o,
    input wire logic led_mode_o,
    input wire logic smi_read_rising_edge_o,
    input wire logic [10:0] storm_threshold_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Write decodes
    // --------------------------------------------------------------
    wire logic w06 = ce_i && reg_wr_i && reg_addr_i == 8'h06;
    wire logic w0b = ce_i && reg_wr_i && reg_addr_i == 8'h0b;
    // Shadow of the replacement enable, rebuilt from register writes.
    logic repl_q;
    always @(posedge clk_i) begin
        if (!rst_n_i) repl_q <= 1'b0;
        else if (w06) repl_q <= reg_wdata_i[3];
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    property p_thr_rst;
        $rose(rst_n_i) |-> storm_threshold_o == 11'h04a;
    endproperty
    a_thr_rst: assert property (p_thr_rst)
        else $error("threshold reset value wrong");
    property p_thr_hi;
        w06 |=> storm_threshold_o[10:8] == $past(reg_wdata_i[2:0]);
    endproperty
    a_thr_hi: assert property (p_thr_hi)
        else $error("threshold high bits wrong");
    property p_ro_b;
        ce_i && reg_rd_i && reg_addr_i == 8'h09
            |=> reg_rvalid_o && reg_rdata_o == 8'h4c;
    endproperty
    a_ro_b: assert property (p_ro_b)
        else $error("factory register read wrong");
    property p_vid_keep;
        vid_valid_i && vid_in_i != 12'h000
            |=> vid_valid_o && vid_out_o == $past(vid_in_i);
    endproperty
    a_vid_keep: assert property (p_vid_keep)
        else $error("identifier changed");
    property p_vid_null;
        vid_valid_i && vid_in_i == 12'h000 |=> vid_valid_o &&
            vid_out_o == ($past(repl_q) ? $past(port_default_vid_i)
                                        : 12'h000);
    endproperty
    a_vid_null: assert property (p_vid_null)
        else $error("null identifier output wrong");
    property p_edge;
        w0b |=> {third_port_reduced_mii_neg_edge_o,
            fourth_port_reduced_mii_neg_edge_o} == $past(reg_wdata_i[7:6]);
    endproperty
    a_edge: assert property (p_edge)
        else $error("sampling edge bits wrong");
    property p_stable;
        !w0b |=> $stable({third_port_reduced_mii_neg_edge_o,
            fourth_port_reduced_mii_neg_edge_o, phy_power_save_o,
            smi_read_rising_edge_o});
    endproperty
    a_stable: assert property (p_stable)
        else $error("control bit moved without write");
    property p_led;
        w0b |=> led_mode_o == $past(reg_wdata_i[1]);
    endproperty
    a_led: assert property (p_led)
        else $error("led mode wrong");
    property p_rde;
        w0b ##1 !w0b |-> smi_read_rising_edge_o == $past(reg_wdata_i[0]);
    endproperty
    a_rde: assert property (p_rde)
        else $error("read edge bit wrong");
    property p_pwr;
        w0b |=> phy_power_save_o == $past(reg_wdata_i[3]);
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("power save bit wrong");
endmodule // gcb_checker

// >>> testbench/testbench.sv
// Self-checking bench for the global control bank.
// Assumes the design sources and the checker are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic vid_valid_i = 1'b0;
    logic [11:0] vid_in_i = 12'h000;
    logic [11:0] dvid = 12'h000;
    logic [3:0] fast = 4'h3;
    logic strap = 1'b1;
    logic [3:0] blk = 4'h0;
    logic [1:0] lnk = 2'h0, act = 2'h0, spd = 2'h0, dup = 2'h0;
    wire [7:0] rdata;
    wire rvalid, vvalid, e3, e4, pwr, ledm, rde;
    wire [11:0] vout;
    wire [3:0] drop, lim;
    wire [1:0] led1, led2;
    wire [10:0] thr;
    logic [7:0] r6 = 8'h00, r7 = 8'h4a, rb = 8'h02, a, d;
    logic [7:0] ro_addr [6] = '{8'h08, 8'h09, 8'h0a, 8'h0c, 8'h00, 8'hff};
    logic [7:0] rw_addr [3] = '{8'h06, 8'h07, 8'h0b};
    int errors = 0, checks_done = 0, i, m, drops [4];
    integer seed;
    switch_global_control_bank #(.FAST_WINDOW_CYCLES(24'h00_0014),
        .SLOW_WINDOW_CYCLES(24'h00_00c8)) dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .vid_valid_i(vid_valid_i),
        .vid_in_i(vid_in_i), .port_default_vid_i(dvid), .vid_valid_o(vvalid),
        .vid_out_o(vout), .fast_port_speed_i(fast), .block_seen_i(blk),
        .block_drop_o(drop), .storm_limited_o(lim), .phy_link_i(lnk),
        .phy_act_i(act), .phy_fast_i(spd), .phy_full_duplex_i(dup),
        .port_led_first_o(led1), .port_led_second_o(led2),
        .led_mode_strap_pin_i(strap), .third_port_reduced_mii_neg_edge_o(e3),
        .fourth_port_reduced_mii_neg_edge_o(e4), .phy_power_save_o(pwr),
        .led_mode_o(ledm), .smi_read_rising_edge_o(rde),
        .storm_threshold_o(thr));
    always #20 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        for (int k = 0; k < 4; k++) drops[k] += drop[k];
    end
    // --------------------------------------------------------------
    // Expectations and bus tasks
    // --------------------------------------------------------------
    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        case (ad)
            8'h06: exp_rd = r6;
            8'h07: exp_rd = r7;
            8'h09: exp_rd = 8'h4c;
            8'h0b: exp_rd = rb;
            default: exp_rd = 8'h00;
        endcase
    endfunction
    function automatic logic [3:0] led_exp();
        if (rb[1]) led_exp = {lnk & spd & ~act, dup};
        else led_exp = {lnk & ~act, spd};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(negedge clk_i);
        reg_addr_i = ad;
        reg_wdata_i = dt;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        if (ad == 8'h06) r6 = dt & 8'h0f;
        if (ad == 8'h07) r7 = dt;
        if (ad == 8'h0b) rb = dt & 8'hcb;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(negedge clk_i);
        reg_addr_i = ad;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        chk({rvalid, rdata}, {1'b1, exp_rd(ad)});
    endtask
    task automatic storm(input logic [7:0] hi, input logic [7:0] lo,
        input int fl, input int fh, input int sl, input int sh);
        wr(8'h06, hi);
        wr(8'h07, lo);
        fast = 4'b0011;
        drops = '{0, 0, 0, 0};
        repeat (200) @(negedge clk_i) blk = 4'hf;
        @(negedge clk_i) blk = 4'h0;
        repeat (2) @(negedge clk_i);
        for (int k = 0; k < 4; k++) begin
            chk(16'(200 - drops[k] >= (k < 2 ? fl : sl)), 16'h0001);
            chk(16'(200 - drops[k] <= (k < 2 ? fh : sh)), 16'h0001);
        end
        if (lo == 8'h00) chk(16'(lim), hi[0] ? 16'h0000 : 16'h000f);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        #(40 * 20000);
        errors++;
        summarize();
    end
    initial begin
        seed = 15638;
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        for (i = 6; i < 12; i++) rd(8'(i));
        chk(16'(ledm), 16'h0001);
        $display("test reset values done");
        foreach (ro_addr[j]) begin
            if (ro_addr[j] > 8'h0a) wr(ro_addr[j], 8'($random(seed)));
            rd(ro_addr[j]);
        end
        $display("test read-only done");
        for (i = 0; i < 24; i++) begin
            a = rw_addr[i % 3];
            wr(a, 8'($random(seed)));
            rd(a);
            chk(16'(thr), {5'h00, r6[2:0], r7});
            chk({e3, e4}, 16'(rb[7:6]));
            chk(16'(pwr), 16'(rb[3]));
            chk(16'(rde), 16'(rb[0]));
            chk(16'(ledm), 16'(rb[1]));
        end
        $display("test register fields done");
        for (m = 0; m < 2; m++) begin
            wr(8'h06, {4'h0, m[0], 3'h1});
            for (i = 0; i < 8; i++) begin
                @(negedge clk_i);
                vid_in_i = i[0] ? 12'($random(seed)) : 12'h000;
                dvid = 12'($random(seed));
                vid_valid_i = 1'b1;
                @(negedge clk_i);
                vid_valid_i = 1'b0;
                d = 8'(r6[3] && vid_in_i == 12'h000);
                chk({vvalid, vout}, {1'b1, d[0] ? dvid : vid_in_i});
            end
        end
        $display("test identifier done");
        storm(8'h00, 8'h02, 20, 22, 2, 4);
        storm(8'h01, 8'h00, 200, 200, 200, 200);
        storm(8'h00, 8'h00, 0, 0, 0, 0);
        $display("test storm done");
        for (m = 0; m < 2; m++) begin
            wr(8'h0b, {6'h00, m[0], 1'b0});
            for (i = 0; i < 8; i++) begin
                @(negedge clk_i);
                {lnk, act, spd, dup} = 8'($random(seed));
                @(negedge clk_i);
                chk({led2, led1}, 16'(led_exp()));
            end
        end
        $display("test leds done");
        strap = 1'b0;
        rst_n_i = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        {r6, r7, rb} = 24'h00_4a00;
        repeat (6) @(negedge clk_i);
        chk(16'(ledm), 16'h0000);
        chk(16'(thr), 16'h004a);
        $display("test strap reset done");
        summarize();
    end
endmodule // testbench
bind switch_global_control_bank gcb_checker chk_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .vid_valid_i(vid_valid_i), .vid_in_i(vid_in_i),
    .port_default_vid_i(port_default_vid_i), .vid_valid_o(vid_valid_o),
    .vid_out_o(vid_out_o),
    .third_port_reduced_mii_neg_edge_o(third_port_reduced_mii_neg_edge_o),
    .fourth_port_reduced_mii_neg_edge_o(fourth_port_reduced_mii_neg_edge_o),
    .phy_power_save_o(phy_power_save_o), .led_mode_o(led_mode_o),
    .smi_read_rising_edge_o(smi_read_rising_edge_o),
    .storm_threshold_o(storm_threshold_o));
